// ### psbld_top.sv
// synthesizer core: nibble latches, two dividers, detector and outputs
`timescale 1ns/1ps
`include "psbld_consts.svh"
module psbld_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [3:0] NIBBLE_BUS,
  input wire logic [2:0] LATCH_SELECT,
  input wire logic LOAD_STROBE,
  input wire logic FREQ_IN,
  input wire logic REFERENCE_CLOCK_INPUT,
  output logic TRISTATE_ERROR_OUTPUT,
  output logic TRISTATE_ERROR_OE_N,
  output logic LOCK_INDICATOR,
  output logic PHI_FB_N,
  output logic PHI_REF_N
);

  // all pins but CLK and RST_N are asynchronous to CLK: two flops before any use
  wire [`PSBLD_SYNC_W-1:0] pins = {REFERENCE_CLOCK_INPUT, FREQ_IN,
                                   LOAD_STROBE, LATCH_SELECT, NIBBLE_BUS};
  logic [`PSBLD_SYNC_W-1:0] sync1;
  logic [`PSBLD_SYNC_W-1:0] sync2;

  genvar gi;
  generate
    for (gi = 0; gi < `PSBLD_SYNC_W; gi++) begin : g_sync
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pins[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  wire psbld_pkg::psbld_nibble_t bus_s = sync2[3:0];
  wire [`PSBLD_SEL_W-1:0] sel_s = sync2[6:4];
  wire strobe_s = sync2[7];
  wire fin_s = sync2[8];
  wire osc_s = sync2[9];

  // previous samples for rising-edge detection of the two clock pins
  logic fin_d;
  logic osc_d;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fin_d <= 1'b0;
      osc_d <= 1'b0;
    end else begin
      fin_d <= fin_s;
      osc_d <= osc_s;
    end
  end

  wire fin_rise = fin_s & ~fin_d;
  wire osc_rise = osc_s & ~osc_d;

  // nibble latches: transparent while strobe high and their code selected, hold once it drops
  psbld_pkg::psbld_nibble_t nib [0:`PSBLD_NUM_LATCH-1];
  wire [`PSBLD_NUM_LATCH-1:0] load_en;

  generate
    for (gi = 0; gi < `PSBLD_NUM_LATCH; gi++) begin : g_latch
      // code 7 matches no entry, so it writes nothing
      assign load_en[gi] = strobe_s & (sel_s == 3'(gi));
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          nib[gi] <= `PSBLD_NIB_RESET;
        end else if (load_en[gi]) begin
          nib[gi] <= bus_s;
        end
      end
    end
  endgenerate

  // bus line 3 lands in bit 3 of each nibble, line 0 in bit 0
  wire [`PSBLD_FB_W-1:0] fb_ratio = {
    nib[`PSBLD_OFS_FB_TOP][`PSBLD_FB_TOP_W-1:0],
    nib[`PSBLD_OFS_FB_NIB2],
    nib[`PSBLD_OFS_FB_NIB1],
    nib[`PSBLD_OFS_FB_NIB0]
  };
  wire [`PSBLD_REF_W-1:0] ref_ratio = {
    nib[`PSBLD_OFS_REF_NIB2],
    nib[`PSBLD_OFS_REF_NIB1],
    nib[`PSBLD_OFS_REF_NIB0]
  };

  psbld_pd_if pd ();

  psbld_divider #(
    .W(`PSBLD_FB_W)
  ) u_fb_div (
    .clk(CLK),
    .rst_n(RST_N),
    .in_edge(fin_rise),
    .ratio(fb_ratio),
    .tick(pd.divided_feedback)
  );

  psbld_divider #(
    .W(`PSBLD_REF_W)
  ) u_ref_div (
    .clk(CLK),
    .rst_n(RST_N),
    .in_edge(osc_rise),
    .ratio(ref_ratio),
    .tick(pd.divided_reference)
  );

  psbld_phase_det u_det (
    .clk(CLK),
    .rst_n(RST_N),
    .pd(pd.det)
  );

  // only one side up means an error is being reported
  wire one_up = pd.fb_up ^ pd.ref_up;
  wire drive_high = pd.ref_up & ~pd.fb_up;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      TRISTATE_ERROR_OUTPUT <= 1'b0;
      TRISTATE_ERROR_OE_N <= 1'b1;
      LOCK_INDICATOR <= 1'b1;
      PHI_FB_N <= 1'b1;
      PHI_REF_N <= 1'b1;
    end else begin
      TRISTATE_ERROR_OUTPUT <= drive_high;
      TRISTATE_ERROR_OE_N <= ~one_up;
      LOCK_INDICATOR <= ~one_up;
      PHI_FB_N <= ~pd.fb_up;
      PHI_REF_N <= ~pd.ref_up;
    end
  end

endmodule

// ### psbld_consts.svh
// offsets, field positions, reset values and widths for the synth loader
`ifndef PSBLD_CONSTS_SVH
`define PSBLD_CONSTS_SVH

`define PSBLD_NIB_W 4
`define PSBLD_SEL_W 3
`define PSBLD_FB_W 14
`define PSBLD_REF_W 12
`define PSBLD_NUM_LATCH 7

`define PSBLD_OFS_FB_NIB0 3'h0
`define PSBLD_OFS_FB_NIB1 3'h1
`define PSBLD_OFS_FB_NIB2 3'h2
`define PSBLD_OFS_FB_TOP 3'h3
`define PSBLD_OFS_REF_NIB0 3'h4
`define PSBLD_OFS_REF_NIB1 3'h5
`define PSBLD_OFS_REF_NIB2 3'h6
`define PSBLD_OFS_NONE 3'h7

`define PSBLD_FB_TOP_W 2
`define PSBLD_FB_POS_NIB0 0
`define PSBLD_FB_POS_NIB1 4
`define PSBLD_FB_POS_NIB2 8
`define PSBLD_FB_POS_TOP 12
`define PSBLD_REF_POS_NIB0 0
`define PSBLD_REF_POS_NIB1 4
`define PSBLD_REF_POS_NIB2 8

`define PSBLD_NIB_RESET 4'h0
`define PSBLD_SYNC_W 10

`endif

// ### psbld_pkg.sv
// types shared by the synth loader and detector modules
package psbld_pkg;

  typedef enum logic [1:0] {
    PFD_IDLE = 2'b00,
    PFD_FB_LEAD = 2'b01,
    PFD_BOTH = 2'b11,
    PFD_REF_LEAD = 2'b10
  } psbld_pfd_e;

  typedef logic [3:0] psbld_nibble_t;

endpackage

// ### psbld_pd_if.sv
// carrier between the divider outputs and the phase detector
`timescale 1ns/1ps
interface psbld_pd_if;
  logic divided_feedback;
  logic divided_reference;
  logic fb_up;
  logic ref_up;

  modport ctl (
    output divided_feedback,
    output divided_reference,
    input fb_up,
    input ref_up
  );

  modport det (
    input divided_feedback,
    input divided_reference,
    output fb_up,
    output ref_up
  );
endinterface

// ### psbld_divider.sv
// programmable down-counting divider, one tick per ratio input edges
`timescale 1ns/1ps
module psbld_divider #(
  parameter int W = 14
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_edge,
  input wire logic [W-1:0] ratio,
  output logic tick
);

  logic [W-1:0] cnt;
  wire expire = (cnt <= W'(1));
  wire [W-1:0] next_cnt = expire ? ratio : cnt - W'(1);

  // a stored ratio of 0 or 1 divides by one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= W'(1);
      tick <= 1'b0;
    end else begin
      tick <= in_edge & expire;
      if (in_edge) begin
        cnt <= next_cnt;
      end
    end
  end

endmodule

// ### psbld_phase_det.sv
// phase/frequency detector state machine on divided edges
`timescale 1ns/1ps
module psbld_phase_det (
  input wire logic clk,
  input wire logic rst_n,
  psbld_pd_if.det pd
);

  psbld_pkg::psbld_pfd_e state;
  psbld_pkg::psbld_pfd_e next_state;

  // from idle or both, fresh ticks decide the next leader
  function automatic psbld_pkg::psbld_pfd_e from_idle(input logic f,
                                                     input logic r);
    psbld_pkg::psbld_pfd_e s;
    s = psbld_pkg::PFD_IDLE;
    if (f && r) begin
      s = psbld_pkg::PFD_BOTH;
    end else if (f) begin
      s = psbld_pkg::PFD_FB_LEAD;
    end else if (r) begin
      s = psbld_pkg::PFD_REF_LEAD;
    end
    return s;
  endfunction

  always_comb begin
    next_state = state;
    unique case (state)
      psbld_pkg::PFD_IDLE: begin
        next_state = from_idle(pd.divided_feedback,
                               pd.divided_reference);
      end
      psbld_pkg::PFD_FB_LEAD: begin
        if (pd.divided_reference) begin
          next_state = psbld_pkg::PFD_BOTH;
        end
      end
      psbld_pkg::PFD_REF_LEAD: begin
        if (pd.divided_feedback) begin
          next_state = psbld_pkg::PFD_BOTH;
        end
      end
      psbld_pkg::PFD_BOTH: begin
        next_state = from_idle(pd.divided_feedback,
                               pd.divided_reference);
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= psbld_pkg::PFD_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign pd.fb_up = state[0];
  assign pd.ref_up = state[1];

endmodule

// ### psbld_host_model.sv
// host model driving latch writes and the two input pins
`timescale 1ns/1ps
module psbld_host_model (
  input wire logic clk,
  output logic [3:0] nib,
  output logic [2:0] sel,
  output logic stb,
  output logic fin,
  output logic rin
);
  initial begin
    {nib, sel, stb, fin, rin} = '0;
  end
  task automatic wr(input logic [2:0] a, input logic [3:0] d);
    @(negedge clk);
    sel = a;
    nib = d;
    @(negedge clk);
    stb = 1'b1;
    repeat (4) @(negedge clk);
    stb = 1'b0;
    repeat (3) @(negedge clk);
    nib = ~d;
    sel = ~a;
  endtask
  // bus changes while the strobe stays high; the later nibble must stick
  task automatic wr_follow(input logic [2:0] a, input logic [3:0] d0,
                           input logic [3:0] d1);
    @(negedge clk);
    sel = a;
    nib = d0;
    @(negedge clk);
    stb = 1'b1;
    repeat (4) @(negedge clk);
    nib = d1;
    repeat (4) @(negedge clk);
    stb = 1'b0;
    repeat (3) @(negedge clk);
    nib = ~d1;
    sel = ~a;
  endtask
  task automatic pulse(input logic f, input logic r, input int n);
    repeat (n) begin
      @(negedge clk);
      fin = f;
      rin = r;
      repeat (3) @(negedge clk);
      fin = 1'b0;
      rin = 1'b0;
      repeat (2) @(negedge clk);
    end
  endtask
endmodule

// ### psbld_top_sva.sv
// assertions on the synth core output pins
`timescale 1ns/1ps
module psbld_top_sva (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic FREQ_IN,
  input wire logic REFERENCE_CLOCK_INPUT,
  input wire logic TRISTATE_ERROR_OUTPUT,
  input wire logic TRISTATE_ERROR_OE_N,
  input wire logic LOCK_INDICATOR,
  input wire logic PHI_FB_N,
  input wire logic PHI_REF_N
);
  int fb_age;
  int rf_age;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // cycles since each pin last rose, saturating
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fb_age <= 99;
      rf_age <= 99;
    end else begin
      fb_age <= $rose(FREQ_IN) ? 0 : fb_age + int'(fb_age < 50);
      rf_age <= $rose(REFERENCE_CLOCK_INPUT) ? 0 : rf_age + int'(rf_age < 50);
    end
  end
  chk_lock_match: assert property (
    LOCK_INDICATOR == (PHI_FB_N == PHI_REF_N))
    else $error("lock disagrees with pulse outputs");
  chk_oe_lock: assert property (
    TRISTATE_ERROR_OE_N == LOCK_INDICATOR)
    else $error("error pin drive disagrees with lock");
  chk_fb_lead_err: assert property (
    (!PHI_FB_N && PHI_REF_N) |-> !TRISTATE_ERROR_OUTPUT)
    else $error("feedback lead without low error");
  chk_ref_lead_err: assert property (
    (PHI_FB_N && !PHI_REF_N) |-> TRISTATE_ERROR_OUTPUT)
    else $error("reference lead without high error");
  chk_match_pulse: assert property (
    (!PHI_FB_N && !PHI_REF_N) |=> (PHI_FB_N || PHI_REF_N))
    else $error("coincident low longer than one cycle");
  chk_no_swap: assert property (
    (!PHI_FB_N && PHI_REF_N) |=> !(PHI_FB_N && !PHI_REF_N))
    else $error("lead swapped sides directly");
  chk_fb_cause: assert property (
    $fell(PHI_FB_N) |-> fb_age < 12)
    else $error("feedback pulse without input edge");
  chk_ref_cause: assert property (
    $fell(PHI_REF_N) |-> rf_age < 12)
    else $error("reference pulse without input edge");
endmodule
bind psbld_top psbld_top_sva u_psbld_top_sva (.CLK, .RST_N, .FREQ_IN,
  .REFERENCE_CLOCK_INPUT, .TRISTATE_ERROR_OUTPUT, .TRISTATE_ERROR_OE_N,
  .LOCK_INDICATOR, .PHI_FB_N, .PHI_REF_N);

// ### tb_psbld_top.sv
// self-checking bench for the synth loader and detector core
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  error_cnt++; $display("Error %s expected %b seen %b", nm, e, g); end end
module tb_psbld_top;
  // nibbles for codes 7..0, then feedback and reference ratios
  logic [63:0] rows [3] = '{64'hf003c005_0005_0003,
    64'hf0120021_0021_0012, 64'hf1040102_0102_0104};
  logic CLK, RST_N, LOAD_STROBE, FREQ_IN, REFERENCE_CLOCK_INPUT;
  logic [3:0] NIBBLE_BUS;
  logic [2:0] LATCH_SELECT;
  logic TRISTATE_ERROR_OUTPUT, TRISTATE_ERROR_OE_N;
  logic LOCK_INDICATOR, PHI_FB_N, PHI_REF_N;
  int error_cnt = 0;
  int comparisons = 0;
  int fb;
  int rf;
  psbld_host_model u_psbld_host_model (.clk(CLK), .nib(NIBBLE_BUS),
    .sel(LATCH_SELECT), .stb(LOAD_STROBE), .fin(FREQ_IN),
    .rin(REFERENCE_CLOCK_INPUT));
  psbld_top u_psbld_top (.CLK, .RST_N, .NIBBLE_BUS, .LATCH_SELECT,
    .LOAD_STROBE, .FREQ_IN, .REFERENCE_CLOCK_INPUT, .TRISTATE_ERROR_OUTPUT,
    .TRISTATE_ERROR_OE_N, .LOCK_INDICATOR, .PHI_FB_N, .PHI_REF_N);
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  task automatic expect_pins(input logic f, input logic r, input logic lk);
    repeat (4) @(negedge CLK);
    `CHK("PHI_FB_N", f, PHI_FB_N)
    `CHK("PHI_REF_N", r, PHI_REF_N)
    `CHK("LOCK_INDICATOR", lk, LOCK_INDICATOR)
    `CHK("TRISTATE_ERROR_OE_N", lk, TRISTATE_ERROR_OE_N)
  endtask
  // called as a pulse ends: the coincident low is on the pins just then
  task automatic expect_match;
    `CHK("PHI_FB_N", 1'b0, PHI_FB_N)
    `CHK("PHI_REF_N", 1'b0, PHI_REF_N)
    `CHK("LOCK_INDICATOR", 1'b1, LOCK_INDICATOR)
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    RST_N = 1'b0;
    repeat (10) @(negedge CLK);
    foreach (rows[k]) begin
      RST_N = 1'b0;
      expect_pins(1'b1, 1'b1, 1'b1);
      RST_N = 1'b1;
      fb = int'(rows[k][31:16]);
      rf = int'(rows[k][15:0]);
      for (int i = 0; i < 8; i++) begin
        u_psbld_host_model.wr(3'(i), rows[k][32+4*i+:4]);
      end
      u_psbld_host_model.pulse(1'b1, 1'b1, 1);
      expect_match();
      expect_pins(1'b1, 1'b1, 1'b1);
      u_psbld_host_model.pulse(1'b1, 1'b0, fb - 1);
      expect_pins(1'b1, 1'b1, 1'b1);
      u_psbld_host_model.pulse(1'b1, 1'b0, 1);
      expect_pins(1'b0, 1'b1, 1'b0);
      `CHK("TRISTATE_ERROR_OUTPUT", 1'b0, TRISTATE_ERROR_OUTPUT)
      u_psbld_host_model.pulse(1'b0, 1'b1, rf);
      expect_match();
      expect_pins(1'b1, 1'b1, 1'b1);
      u_psbld_host_model.pulse(1'b0, 1'b1, rf);
      expect_pins(1'b1, 1'b0, 1'b0);
      `CHK("TRISTATE_ERROR_OUTPUT", 1'b1, TRISTATE_ERROR_OUTPUT)
      u_psbld_host_model.pulse(1'b1, 1'b0, fb);
      expect_match();
      expect_pins(1'b1, 1'b1, 1'b1);
    end
    // latch 0 follows the bus while strobed: ratio 2, not 5
    RST_N = 1'b0;
    expect_pins(1'b1, 1'b1, 1'b1);
    RST_N = 1'b1;
    u_psbld_host_model.wr_follow(3'h0, 4'h5, 4'h2);
    u_psbld_host_model.pulse(1'b1, 1'b1, 1);
    expect_match();
    u_psbld_host_model.pulse(1'b1, 1'b0, 1);
    expect_pins(1'b1, 1'b1, 1'b1);
    u_psbld_host_model.pulse(1'b1, 1'b0, 1);
    expect_pins(1'b0, 1'b1, 1'b0);
    // reset in the middle of a lead returns the detector to idle
    RST_N = 1'b0;
    expect_pins(1'b1, 1'b1, 1'b1);
    `CHK("TRISTATE_ERROR_OUTPUT", 1'b0, TRISTATE_ERROR_OUTPUT)
    RST_N = 1'b1;
    expect_pins(1'b1, 1'b1, 1'b1);
    u_psbld_host_model.pulse(1'b0, 1'b1, 1);
    expect_pins(1'b1, 1'b0, 1'b0);
    `CHK("TRISTATE_ERROR_OUTPUT", 1'b1, TRISTATE_ERROR_OUTPUT)
    u_psbld_host_model.pulse(1'b1, 1'b0, 1);
    expect_match();
    expect_pins(1'b1, 1'b1, 1'b1);
    report_and_stop();
  end
endmodule
